// *** cwg_pkg.sv ***
// Package: register map, field positions, reset values and modes of the waveform shaper
// Notes on behaviour
// - Rise delay precedes a (half) or b (full)
// - Rise delay buffered; disabled writes load at once
// - Enabled: load request moves rise on falling edge
// - Fall delay precedes b (half) or d (full)
// - Fall delay buffered; disabled writes load at once
// - Enabled: load request moves fall on falling edge
// - Pulse shorter than delay gives no output
// - Delay uncertainty at most one module clock
// - Direction change applies at next rising input
// - a, c switch at once; b, d delayed once
// - Steered outputs carry input, others fixed level
// - Polarity inverts only steered outputs
// - Shutdown overrides only steered outputs
// - Mode 000 applies steering immediately
// - Mode 001 applies steering at rising input
// - Shutdown bit forces shutdown while set
// - Auto-restart clears shutdown bit, resumes on rise
// - Selected external source forces override levels
// - Four active-low shutdown sources are selectable
// - Shutdown sources level sensitive, hold shutdown
// - Keep oscillator requested when enabled, active, selected
// - Clock select bit only gates the oscillator request; MCLK stays the module clock
// - Two 6-bit counters time the dead band
// - Two-bit fields set override levels, polarity-free
// - Overrides stay until first rising input edge
package cwg_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CONTROL_0 = 8'h00;
  localparam logic [7:0] OFS_CONTROL_1 = 8'h04;
  localparam logic [7:0] OFS_CLOCK_SELECT = 8'h08;
  localparam logic [7:0] OFS_RISE_DEADBAND = 8'h0C;
  localparam logic [7:0] OFS_FALL_DEADBAND = 8'h10;
  localparam logic [7:0] OFS_SHUTDOWN_CONTROL = 8'h14;
  localparam logic [7:0] OFS_SHUTDOWN_SOURCE = 8'h18;
  localparam logic [7:0] OFS_STEERING = 8'h1C;
  localparam logic [7:0] OFS_ACTIVE_DEADBAND = 8'h20;

  // ==========================================================
  // Field positions
  localparam int ENABLE_BIT = 7;
  localparam int LOAD_BIT = 6;
  localparam int INPUT_STATE_BIT = 5;
  localparam int SHUTDOWN_BIT = 7;
  localparam int RESTART_BIT = 6;
  localparam int LEVEL_BD_LSB = 4;
  localparam int LEVEL_AC_LSB = 2;
  localparam int FIXED_LEVEL_LSB = 4;
  localparam int ACTIVE_FALL_LSB = 8;
  localparam int DB_WIDTH = 6;

  // ==========================================================
  // Reset values and counts
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [3:0] POLARITY_RESET = 4'hF;
  localparam logic [DB_WIDTH-1:0] DEADBAND_RESET = 6'h00;
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic [7:0] ACTIVITY_CYCLES = 8'hFF;

  // ==========================================================
  // Output modes
  typedef enum logic [2:0] {
    MODE_STEER = 3'b000,
    MODE_SYNC_STEER = 3'b001,
    MODE_BRIDGE_FWD = 3'b010,
    MODE_BRIDGE_REV = 3'b011,
    MODE_HALF_BRIDGE = 3'b100,
    MODE_PUSH_PULL = 3'b101
  } mode_t;

endpackage

// *** deadband_counter.sv ***
// Dead-band delay counter: releases its arm level after a programmed count
`timescale 1ns/10ps
`default_nettype none
module deadband_counter (
  input wire logic clk, // Module clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic arm, // Level waiting to be delayed
  input wire logic [cwg_pkg::DB_WIDTH-1:0] limit, // Programmed delay in clocks
  output logic released // Arm seen for limit clocks
);

  logic [cwg_pkg::DB_WIDTH-1:0] count;

  wire logic at_limit = (count == limit);

  // Dropping arm restarts from zero, so a short pulse never releases
  always_ff @(posedge clk) begin
    if (!rst_n || !arm) begin
      count <= '0;
    end else if (!at_limit) begin
      count <= count + 6'h01;
    end
  end

  assign released = arm & at_limit;

endmodule
`default_nettype wire

// *** deadband_steering_shutdown.sv ***
// Top: dead band, steering and auto-shutdown of a complementary waveform generator
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module deadband_steering_shutdown (
  input wire logic MCLK, // Module clock, 20 MHz
  input wire logic RSTN, // Synchronous reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction, high for write
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic WAVE_IN, // Selected input waveform
  input wire logic COMPARATOR1_SYNC_OUT_N, // Shutdown source 0, active low
  input wire logic COMPARATOR2_SYNC_OUT_N, // Shutdown source 1, active low
  input wire logic TIMER_TWO_POSTSCALED_OUT_N, // Shutdown source 2, active low
  input wire logic SHUTDOWN_INPUT_PIN_N, // Shutdown source 3, active low
  output logic WAVE_OUT_A, // Output a
  output logic WAVE_OUT_B, // Output b
  output logic WAVE_OUT_C, // Output c
  output logic WAVE_OUT_D, // Output d
  output logic INTERNAL_HF_OSCILLATOR_REQ // Keep internal oscillator running
);

  // ==========================================================
  // State
  logic enable;
  logic buffer_load_request;
  logic [2:0] mode;
  logic [3:0] output_polarity;
  logic clock_select;
  logic [5:0] rise_deadband_reg;
  logic [5:0] fall_deadband_reg;
  logic [5:0] rise_active;
  logic [5:0] fall_active;
  logic shutdown;
  logic restart_enable;
  logic [1:0] override_level_bd;
  logic [1:0] override_level_ac;
  logic [3:0] shutdown_source_select;
  logic [3:0] steer_select;
  logic [3:0] fixed_level;
  logic [3:0] steer_active;
  logic wave_prev;
  logic dir_reverse;
  logic db_pending;
  logic override_hold;
  logic [7:0] idle_count;
  logic [3:0] wave_out;
  logic [31:0] next_prdata;
  logic [3:0] act;

  // ==========================================================
  // APB decode
  wire logic setup = PSEL & ~PENABLE;
  wire logic wr = PSEL & PENABLE & PREADY & PWRITE;
  wire logic wr_ctrl0 = wr & (PADDR == cwg_pkg::OFS_CONTROL_0);
  wire logic wr_ctrl1 = wr & (PADDR == cwg_pkg::OFS_CONTROL_1);
  wire logic wr_clk = wr & (PADDR == cwg_pkg::OFS_CLOCK_SELECT);
  wire logic wr_rise = wr & (PADDR == cwg_pkg::OFS_RISE_DEADBAND);
  wire logic wr_fall = wr & (PADDR == cwg_pkg::OFS_FALL_DEADBAND);
  wire logic wr_shut = wr & (PADDR == cwg_pkg::OFS_SHUTDOWN_CONTROL);
  wire logic wr_src = wr & (PADDR == cwg_pkg::OFS_SHUTDOWN_SOURCE);
  wire logic wr_steer = wr & (PADDR == cwg_pkg::OFS_STEERING);
  wire logic mapped = (PADDR[1:0] == 2'h0) && (PADDR <= cwg_pkg::OFS_ACTIVE_DEADBAND);

  // ==========================================================
  // Input edges and mode decode
  wire logic wave = WAVE_IN & enable;
  wire logic rise_edge = wave & ~wave_prev;
  wire logic fall_edge = ~wave & wave_prev;
  wire logic steering = (mode[2:1] == 2'b00);
  wire logic bridge = (mode[2:1] == 2'b01);
  wire logic half = (mode == cwg_pkg::MODE_HALF_BRIDGE);
  wire logic load_xfer = enable & buffer_load_request & fall_edge;
  wire logic wr_load = wr_ctrl0 & PWDATA[cwg_pkg::LOAD_BIT] & enable;

  // ==========================================================
  // Shutdown sources, all active low, order {pin, timer, cmp2, cmp1}
  wire logic [3:0] source_low = ~{SHUTDOWN_INPUT_PIN_N, TIMER_TWO_POSTSCALED_OUT_N,
                                  COMPARATOR2_SYNC_OUT_N, COMPARATOR1_SYNC_OUT_N};
  wire logic ext_active = |(shutdown_source_select & source_low);
  wire logic shutdown_now = shutdown | ext_active;
  wire logic override = shutdown_now | override_hold;

  // ==========================================================
  // Control register 0 and load request
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      enable <= 1'b0;
      mode <= cwg_pkg::MODE_RESET;
    end else if (wr_ctrl0) begin
      enable <= PWDATA[cwg_pkg::ENABLE_BIT];
      mode <= PWDATA[2:0];
    end
  end

  // A software set arriving with the transfer keeps the request pending
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      buffer_load_request <= 1'b0;
    end else if (wr_load) begin
      buffer_load_request <= 1'b1;
    end else if (load_xfer || !enable) begin
      buffer_load_request <= 1'b0;
    end
  end

  // ==========================================================
  // Polarity, clock select, steering and source registers
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      output_polarity <= cwg_pkg::POLARITY_RESET;
      clock_select <= 1'b0;
      shutdown_source_select <= 4'h0;
      steer_select <= 4'h0;
      fixed_level <= 4'h0;
    end else begin
      if (wr_ctrl1) output_polarity <= PWDATA[3:0];
      if (wr_clk) clock_select <= PWDATA[0];
      if (wr_src) shutdown_source_select <= PWDATA[3:0];
      if (wr_steer) begin
        steer_select <= PWDATA[3:0];
        fixed_level <= PWDATA[cwg_pkg::FIXED_LEVEL_LSB +: 4];
      end
    end
  end

  // Mode 000 takes a write straight away, even mid-pulse
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      steer_active <= 4'h0;
    end else if (mode == cwg_pkg::MODE_STEER) begin
      steer_active <= wr_steer ? PWDATA[3:0] : steer_select;
    end else if (rise_edge) begin
      steer_active <= steer_select;
    end
  end

  // ==========================================================
  // Double-buffered dead-band values
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      rise_deadband_reg <= cwg_pkg::DEADBAND_RESET;
      fall_deadband_reg <= cwg_pkg::DEADBAND_RESET;
      rise_active <= cwg_pkg::DEADBAND_RESET;
      fall_active <= cwg_pkg::DEADBAND_RESET;
    end else begin
      if (wr_rise) rise_deadband_reg <= PWDATA[5:0];
      if (wr_fall) fall_deadband_reg <= PWDATA[5:0];
      if (wr_rise && !enable) begin
        rise_active <= PWDATA[5:0];
      end else if (load_xfer) begin
        rise_active <= rise_deadband_reg;
      end
      if (wr_fall && !enable) begin
        fall_active <= PWDATA[5:0];
      end else if (load_xfer) begin
        fall_active <= fall_deadband_reg;
      end
    end
  end

  // ==========================================================
  // Shutdown bit and override hold
  // A live source wins over any software clear or auto-restart
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      shutdown <= 1'b0;
      restart_enable <= 1'b0;
      override_level_bd <= cwg_pkg::LEVEL_RESET;
      override_level_ac <= cwg_pkg::LEVEL_RESET;
    end else begin
      if (wr_shut) begin
        restart_enable <= PWDATA[cwg_pkg::RESTART_BIT];
        override_level_bd <= PWDATA[cwg_pkg::LEVEL_BD_LSB +: 2];
        override_level_ac <= PWDATA[cwg_pkg::LEVEL_AC_LSB +: 2];
      end
      if (ext_active) begin
        shutdown <= 1'b1;
      end else if (wr_shut) begin
        shutdown <= PWDATA[cwg_pkg::SHUTDOWN_BIT];
      end else if (restart_enable) begin
        shutdown <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      override_hold <= 1'b0;
    end else if (shutdown_now) begin
      override_hold <= 1'b1;
    end else if (rise_edge) begin
      override_hold <= 1'b0;
    end
  end

  // ==========================================================
  // Full-bridge direction tracking
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      wave_prev <= 1'b0;
      dir_reverse <= 1'b0;
      db_pending <= 1'b0;
    end else begin
      wave_prev <= wave;
      if (rise_edge && bridge) begin
        dir_reverse <= mode[0];
        db_pending <= (mode[0] != dir_reverse);
      end else if (fall_edge || !bridge) begin
        db_pending <= 1'b0;
      end
    end
  end

  // Direction as it stands from this edge on, so the old direction cannot pulse at the change
  wire logic dir_now = (rise_edge && bridge) ? mode[0] : dir_reverse;
  wire logic db_now = (rise_edge && bridge) ? (mode[0] != dir_reverse) : db_pending;

  // ==========================================================
  // Dead-band counters
  // Edges are sampled on MCLK, so the delay can stretch by one clock
  wire logic rise_arm = half ? wave : (bridge & db_now & dir_now & wave);
  wire logic fall_arm = half ? (enable & ~wave) : (bridge & db_now & ~dir_now & wave);
  wire logic rise_done;
  wire logic fall_done;

  deadband_counter rise_counter (
    .clk(MCLK),
    .rst_n(RSTN),
    .arm(rise_arm),
    .limit(rise_active),
    .released(rise_done)
  );

  deadband_counter fall_counter (
    .clk(MCLK),
    .rst_n(RSTN),
    .arm(fall_arm),
    .limit(fall_active),
    .released(fall_done)
  );

  // ==========================================================
  // Active-state waveform per mode, bits {d, c, b, a}
  always_comb begin
    act = 4'h0;
    case (mode)
      cwg_pkg::MODE_HALF_BRIDGE: begin
        act = {~wave, wave, fall_done, rise_done};
      end
      cwg_pkg::MODE_BRIDGE_FWD, cwg_pkg::MODE_BRIDGE_REV: begin
        if (dir_now) begin
          act = {1'b0, enable, db_now ? rise_done : wave, 1'b0};
        end else begin
          act = {db_now ? fall_done : wave, 1'b0, 1'b0, enable};
        end
      end
      default: begin
        act = 4'h0;
      end
    endcase
  end

  // Steered bits follow input through polarity; fixed bits ignore polarity
  wire logic [3:0] steer_drive = (steer_active & (output_polarity ~^ {4{wave}})) |
                                 (~steer_active & fixed_level);
  wire logic [3:0] drive = steering ? steer_drive : (output_polarity ~^ act);
  wire logic [3:0] affected = steering ? steer_active : 4'hF;
  wire logic [3:0] level = {override_level_bd[0], override_level_ac[0],
                            override_level_bd[0], override_level_ac[0]};
  wire logic [3:0] ovr_mask = {4{override}} & affected;
  wire logic [3:0] next_wave_out = (ovr_mask & level) | (~ovr_mask & drive);

  // ==========================================================
  // Input activity and oscillator request
  wire logic input_active = (idle_count != cwg_pkg::ACTIVITY_CYCLES);
  wire logic next_osc_req = enable & input_active & clock_select;

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      idle_count <= cwg_pkg::ACTIVITY_CYCLES;
      wave_out <= 4'h0;
      INTERNAL_HF_OSCILLATOR_REQ <= 1'b0;
    end else begin
      if (rise_edge || fall_edge) begin
        idle_count <= 8'h00;
      end else if (input_active) begin
        idle_count <= idle_count + 8'h01;
      end
      wave_out <= next_wave_out;
      INTERNAL_HF_OSCILLATOR_REQ <= next_osc_req;
    end
  end

  assign WAVE_OUT_A = wave_out[0];
  assign WAVE_OUT_B = wave_out[1];
  assign WAVE_OUT_C = wave_out[2];
  assign WAVE_OUT_D = wave_out[3];

  // ==========================================================
  // APB read mux and answer
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (PADDR)
      cwg_pkg::OFS_CONTROL_0: begin
        next_prdata[cwg_pkg::ENABLE_BIT] = enable;
        next_prdata[cwg_pkg::LOAD_BIT] = buffer_load_request;
        next_prdata[2:0] = mode;
      end
      cwg_pkg::OFS_CONTROL_1: begin
        next_prdata[cwg_pkg::INPUT_STATE_BIT] = WAVE_IN;
        next_prdata[3:0] = output_polarity;
      end
      cwg_pkg::OFS_CLOCK_SELECT: next_prdata[0] = clock_select;
      cwg_pkg::OFS_RISE_DEADBAND: next_prdata[5:0] = rise_deadband_reg;
      cwg_pkg::OFS_FALL_DEADBAND: next_prdata[5:0] = fall_deadband_reg;
      cwg_pkg::OFS_SHUTDOWN_CONTROL: begin
        next_prdata[cwg_pkg::SHUTDOWN_BIT] = shutdown_now;
        next_prdata[cwg_pkg::RESTART_BIT] = restart_enable;
        next_prdata[cwg_pkg::LEVEL_BD_LSB +: 2] = override_level_bd;
        next_prdata[cwg_pkg::LEVEL_AC_LSB +: 2] = override_level_ac;
      end
      cwg_pkg::OFS_SHUTDOWN_SOURCE: next_prdata[3:0] = shutdown_source_select;
      cwg_pkg::OFS_STEERING: begin
        next_prdata[3:0] = steer_select;
        next_prdata[cwg_pkg::FIXED_LEVEL_LSB +: 4] = fixed_level;
      end
      cwg_pkg::OFS_ACTIVE_DEADBAND: begin
        next_prdata[5:0] = rise_active;
        next_prdata[cwg_pkg::ACTIVE_FALL_LSB +: 6] = fall_active;
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // One wait-free access phase: ready is raised by the setup cycle
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup & ~mapped;
      if (setup) PRDATA <= PWRITE ? 32'h0000_0000 : next_prdata;
    end
  end

endmodule
`default_nettype wire

// *** deadband_steering_shutdown_chk.sv ***
// Checker: bus timing, reset quiet and oscillator release of the waveform shaper
`timescale 1ns/10ps
`default_nettype none
module dss_chk (
  input wire logic MCLK, // Module clock
  input wire logic RSTN, // Synchronous reset, active low
  input wire logic PSEL, // Bus select
  input wire logic PENABLE, // Bus enable
  input wire logic PWRITE, // Bus direction
  input wire logic [7:0] PADDR, // Bus address
  input wire logic [31:0] PRDATA, // Read data
  input wire logic PREADY, // Ready
  input wire logic PSLVERR, // Error
  input wire logic WAVE_IN, // Input waveform
  input wire logic WAVE_OUT_A, // Output a
  input wire logic WAVE_OUT_B, // Output b
  input wire logic WAVE_OUT_C, // Output c
  input wire logic WAVE_OUT_D, // Output d
  input wire logic INTERNAL_HF_OSCILLATOR_REQ // Oscillator request
);
  // ==========================================================
  // Helper logic
  logic last_in;
  logic [8:0] quiet;
  wire logic bad_addr;
  assign bad_addr = (PADDR > 8'h20) || (PADDR[1:0] != 2'h0);
  // Saturates so a long idle input cannot wrap back under the bound
  always_ff @(posedge MCLK) begin
    last_in <= WAVE_IN;
    if (!RSTN || WAVE_IN != last_in) begin
      quiet <= 9'h000;
    end else if (quiet != 9'h1FF) begin
      quiet <= quiet + 9'h001;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence answer_s;
    PREADY && PSEL && PENABLE;
  endsequence
  rdy_after_setup_a: assert property (setup_s |=> answer_s)
    else $error("no answer in the cycle after setup");
  rdy_single_a: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  rdy_cause_a: assert property (PREADY |-> $past(PSEL && !PENABLE))
    else $error("ready without a setup cycle");
  err_unmapped_a: assert property (setup_s ##0 bad_addr |=> PSLVERR)
    else $error("unmapped address not refused");
  err_mapped_a: assert property (setup_s ##0 !bad_addr |=> !PSLVERR)
    else $error("mapped address refused");
  err_needs_rdy_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  rd_err_zero_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("refused read returned data");
  rdata_hold_a: assert property ($changed(PRDATA) |-> PREADY)
    else $error("read data changed outside an access");
  reset_quiet_a: assert property ($rose(RSTN) |-> !PREADY && !PSLVERR && PRDATA == 32'h0 &&
    {WAVE_OUT_D, WAVE_OUT_C, WAVE_OUT_B, WAVE_OUT_A} == 4'h0 && !INTERNAL_HF_OSCILLATOR_REQ)
    else $error("outputs not cleared by reset");
  osc_idle_a: assert property (quiet >= 9'h12C |-> !INTERNAL_HF_OSCILLATOR_REQ)
    else $error("oscillator held with an idle input");
endmodule
bind deadband_steering_shutdown dss_chk u_dss_chk (.MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .WAVE_IN(WAVE_IN), .WAVE_OUT_A(WAVE_OUT_A), .WAVE_OUT_B(WAVE_OUT_B),
  .WAVE_OUT_C(WAVE_OUT_C), .WAVE_OUT_D(WAVE_OUT_D),
  .INTERNAL_HF_OSCILLATOR_REQ(INTERNAL_HF_OSCILLATOR_REQ));
`default_nettype wire

// *** gate_driver_model.sv ***
// Gate-driver model: counts cycles in which both switches of one leg conduct
`timescale 1ns/10ps
`default_nettype none
module gate_driver_model (
  input wire logic clk, // Module clock
  input wire logic rst_n, // Reset, active low
  input wire logic watch, // Count only while high
  input wire logic high_a, // High-side gate of the leg
  input wire logic low_b, // Low-side gate of the leg
  output logic [7:0] overlaps // Shoot-through cycles seen
);
  // ==========================================================
  // Both gates on at once shorts the supply; dead band must prevent it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overlaps <= 8'h00;
    end else if (watch && high_a && low_b) begin
      overlaps <= overlaps + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Testbench: register bus, steering, dead band, direction and shutdown scenarios
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic wave_in = 1'h0;
  logic watch = 1'h0;
  logic [3:0] src_n = 4'hF;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready;
  logic pslverr;
  logic slverr;
  logic req;
  logic [3:0] outs;
  logic [3:0] seen;
  logic [7:0] overlaps;
  int err_count = 0;
  int num_checks = 0;
  int d;
  // Rows: steer, fixed levels, polarity, input level, expected {d,c,b,a}
  logic [16:0] rows [8] = '{{4'hF, 4'h0, 4'hF, 1'h1, 4'hF}, {4'hF, 4'h0, 4'hF, 1'h0, 4'h0},
    {4'hF, 4'h0, 4'h0, 1'h1, 4'h0}, {4'hF, 4'h0, 4'h0, 1'h0, 4'hF},
    {4'h0, 4'h6, 4'h0, 1'h1, 4'h6}, {4'h3, 4'h0, 4'h5, 1'h1, 4'h1},
    {4'h5, 4'hA, 4'hF, 1'h1, 4'hF}, {4'h5, 4'hA, 4'hF, 1'h0, 4'hA}};

  deadband_steering_shutdown u_deadband_steering_shutdown (.MCLK(mclk), .RSTN(rstn),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .WAVE_IN(wave_in),
    .COMPARATOR1_SYNC_OUT_N(src_n[0]), .COMPARATOR2_SYNC_OUT_N(src_n[1]),
    .TIMER_TWO_POSTSCALED_OUT_N(src_n[2]), .SHUTDOWN_INPUT_PIN_N(src_n[3]),
    .WAVE_OUT_A(outs[0]), .WAVE_OUT_B(outs[1]), .WAVE_OUT_C(outs[2]), .WAVE_OUT_D(outs[3]),
    .INTERNAL_HF_OSCILLATOR_REQ(req));
  gate_driver_model u_gate_driver_model (.clk(mclk), .rst_n(rstn), .watch(watch),
    .high_a(outs[0]), .low_b(outs[1]), .overlaps(overlaps));

  always #25 mclk = ~mclk;

  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rdata = prdata;
    slverr = pslverr;
    check(32'(n < 50), 32'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'h1, a, wd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(rdata, exp);
  endtask
  task automatic set_in(input logic v);
    @(posedge mclk) wave_in <= v;
  endtask
  // Outputs are registered, so two edges pass before looking
  task automatic settle;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask
  // Cycles between output i and output j turning active
  task automatic meas(input int i, input int j, output int dd);
    int ti;
    int tj;
    ti = -1;
    tj = -1;
    seen = 4'h0;
    for (int k = 0; k < 100 && (ti < 0 || tj < 0); k++) begin
      @(negedge mclk);
      seen = seen | outs;
      if (ti < 0 && outs[i] === 1'h1) ti = k;
      if (tj < 0 && outs[j] === 1'h1) tj = k;
    end
    dd = tj - ti;
  endtask
  task automatic finish_test;
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    err_count++;
    $display("Error at %0t: timeout", $time);
    finish_test;
  end

  // ==========================================================
  // Sequence
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'h1;
    rdc(cwg_pkg::OFS_CONTROL_0, 32'h0);
    rdc(cwg_pkg::OFS_CONTROL_1, 32'h0F);
    check(32'(outs), 32'h0);
    rdc(8'h24, 32'h0);
    check(32'(slverr), 32'h1);
    wr(cwg_pkg::OFS_CONTROL_0, 32'h80);
    for (int i = 0; i < 8; i++) begin
      wr(cwg_pkg::OFS_STEERING, {24'h0, rows[i][12:9], rows[i][16:13]});
      wr(cwg_pkg::OFS_CONTROL_1, {28'h0, rows[i][8:5]});
      set_in(rows[i][4]);
      settle;
      check(32'(outs), 32'(rows[i][3:0]));
    end
    wr(cwg_pkg::OFS_STEERING, 32'h0F);
    set_in(1'h1);
    settle;
    check(32'(outs), 32'hF);
    wr(cwg_pkg::OFS_STEERING, 32'h00);
    settle;
    check(32'(outs), 32'h0);
    wr(cwg_pkg::OFS_CONTROL_0, 32'h81);
    wr(cwg_pkg::OFS_STEERING, 32'h01);
    settle;
    check(32'(outs), 32'h0);
    set_in(1'h0);
    set_in(1'h1);
    settle;
    check(32'(outs), 32'h1);
    set_in(1'h0);
    wr(cwg_pkg::OFS_CONTROL_0, 32'h04);
    wr(cwg_pkg::OFS_RISE_DEADBAND, 32'h03);
    wr(cwg_pkg::OFS_FALL_DEADBAND, 32'h04);
    rdc(cwg_pkg::OFS_ACTIVE_DEADBAND, 32'h0403);
    wr(cwg_pkg::OFS_CONTROL_0, 32'h84);
    @(posedge mclk) watch <= 1'h1;
    set_in(1'h1);
    meas(2, 0, d);
    check(32'(d), 32'h3);
    set_in(1'h0);
    meas(3, 1, d);
    check(32'(d), 32'h4);
    set_in(1'h1);
    set_in(1'h0);
    d = 0;
    repeat (10) begin
      @(negedge mclk);
      if (outs[0] === 1'h1) d = 1;
    end
    check(32'(d), 32'h0);
    check(32'(overlaps), 32'h0);
    @(posedge mclk) watch <= 1'h0;
    wr(cwg_pkg::OFS_RISE_DEADBAND, 32'h05);
    wr(cwg_pkg::OFS_FALL_DEADBAND, 32'h02);
    rdc(cwg_pkg::OFS_ACTIVE_DEADBAND, 32'h0403);
    wr(cwg_pkg::OFS_CONTROL_0, 32'hC4);
    rdc(cwg_pkg::OFS_CONTROL_0, 32'hC4);
    set_in(1'h1);
    set_in(1'h0);
    settle;
    rdc(cwg_pkg::OFS_ACTIVE_DEADBAND, 32'h0205);
    rdc(cwg_pkg::OFS_CONTROL_0, 32'h84);
    wr(cwg_pkg::OFS_ACTIVE_DEADBAND, 32'hFFFF);
    rdc(cwg_pkg::OFS_ACTIVE_DEADBAND, 32'h0205);
    wr(cwg_pkg::OFS_CONTROL_0, 32'h82);
    set_in(1'h1);
    set_in(1'h0);
    settle;
    check(32'(outs), 32'h1);
    wr(cwg_pkg::OFS_CONTROL_0, 32'h83);
    settle;
    check(32'(outs), 32'h1);
    set_in(1'h1);
    meas(2, 1, d);
    check(32'(d), 32'h5);
    check(32'(seen[3]), 32'h0);
    check(32'(outs), 32'h6);
    set_in(1'h0);
    set_in(1'h1);
    settle;
    check(32'(outs), 32'h6);
    wr(cwg_pkg::OFS_CLOCK_SELECT, 32'h1);
    set_in(1'h0);
    settle;
    check(32'(req), 32'h1);
    repeat (300) @(posedge mclk);
    @(negedge mclk);
    check(32'(req), 32'h0);
    wr(cwg_pkg::OFS_CLOCK_SELECT, 32'h0);
    set_in(1'h1);
    settle;
    check(32'(req), 32'h0);
    wr(cwg_pkg::OFS_CONTROL_0, 32'h80);
    wr(cwg_pkg::OFS_STEERING, 32'h0F);
    wr(cwg_pkg::OFS_CONTROL_1, 32'h0);
    wr(cwg_pkg::OFS_SHUTDOWN_CONTROL, 32'h90);
    set_in(1'h0);
    set_in(1'h1);
    settle;
    check(32'(outs), 32'hA);
    wr(cwg_pkg::OFS_SHUTDOWN_CONTROL, 32'h10);
    settle;
    check(32'(outs), 32'hA);
    set_in(1'h0);
    set_in(1'h1);
    settle;
    check(32'(outs), 32'h0);
    wr(cwg_pkg::OFS_CONTROL_1, 32'h0F);
    wr(cwg_pkg::OFS_STEERING, 32'h05);
    wr(cwg_pkg::OFS_SHUTDOWN_CONTROL, 32'h50);
    wr(cwg_pkg::OFS_SHUTDOWN_SOURCE, 32'hF);
    for (int s = 0; s < 4; s++) begin
      @(posedge mclk) src_n <= ~(4'h1 << s);
      settle;
      check(32'(outs), 32'h0);
      wr(cwg_pkg::OFS_SHUTDOWN_CONTROL, 32'h50);
      settle;
      check(32'(outs), 32'h0);
      @(posedge mclk) src_n <= 4'hF;
      settle;
      rdc(cwg_pkg::OFS_SHUTDOWN_CONTROL, 32'h50);
      check(32'(outs), 32'h0);
      set_in(1'h0);
      set_in(1'h1);
      settle;
      check(32'(outs), 32'h5);
    end
    finish_test;
  end
endmodule
`default_nettype wire
